// *** common/eeprom_seq_pkg.sv ***
// Constants, field layouts and carriers for the byte-write sequencer.
// Assumes a 20 MHz system clock and a core that writes the set-up fields
// through one write strobe with a field select.
//
// Contract
// [RULE_01] Region select zero sends writes and table reads to code flash.
// [RULE_02] Region select two sends writes and table reads to the data EEPROM.
// [RULE_03] Software loads the data byte before starting a write.
// [RULE_04] Software loads the 14-bit target address, high six and low eight.
// [RULE_05] Nonzero arming count n enables writing for n clocks, then disables.
// [RULE_06] Software issues the control write inside the armed window.
// [RULE_07] Valid hold time plus write command stalls the core and programs.
// [RULE_08] Shortest hold with write command programs and holds core 1.5 ms.
// [RULE_09] When programming ends the stall is released.
// [RULE_10] Software runs eight no-operations right after the write command.
// [RULE_11] Code-protect option makes code-area writes do nothing.
// [RULE_12] Region one or two sends table accesses to information block or EEPROM.
// [RULE_13] Software masks interrupts around region one or two use.
// [RULE_14] EEPROM selected: table read at offset returns EEPROM byte there.
// [RULE_15] For EEPROM, software writes zero high address and offset low.
// [RULE_16] Hold field: 00 gives 6 ms, 01 gives 3 ms, 10 gives 1.5 ms.
// [RULE_17] Command field starts a write only for code 10.
// [RULE_18] During stall interrupt events are kept, one request per source.
// [RULE_19] Region one allows reading the identification area, never writing.
// [RULE_20] Unarmed or late write command is ignored without any stall.
package eeprom_seq_pkg;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_MHZ = 20;
	localparam int HOLD_LONG_US = 6000;
	localparam int HOLD_MID_US = 3000;
	localparam int HOLD_SHORT_US = 1500;
	localparam int HOLD_LONG_CYCLES = HOLD_LONG_US * CLK_MHZ;
	localparam int HOLD_MID_CYCLES = HOLD_MID_US * CLK_MHZ;
	localparam int HOLD_SHORT_CYCLES = HOLD_SHORT_US * CLK_MHZ;
	localparam int HOLD_CNT_W = 17;

	// --------------------------------------------------------------
	// Field selects for the core's set-up writes
	// --------------------------------------------------------------
	localparam logic [2:0] SEL_REGION = 3'h0;
	localparam logic [2:0] SEL_DATA = 3'h1;
	localparam logic [2:0] SEL_ADDR_HIGH = 3'h2;
	localparam logic [2:0] SEL_ADDR_LOW = 3'h3;
	localparam logic [2:0] SEL_ARM = 3'h4;
	localparam logic [2:0] SEL_CONTROL = 3'h5;

	// --------------------------------------------------------------
	// Region codes, control fields and reset values
	// --------------------------------------------------------------
	localparam logic [7:0] REGION_CODE = 8'h00;
	localparam logic [7:0] REGION_INFO = 8'h01;
	localparam logic [7:0] REGION_EEPROM = 8'h02;
	localparam logic [1:0] HOLD_LONG = 2'h0;
	localparam logic [1:0] HOLD_MID = 2'h1;
	localparam logic [1:0] HOLD_SHORT = 2'h2;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam int CTRL_HOLD_LSB = 2;
	localparam int CTRL_CMD_LSB = 0;
	localparam int ADDR_HIGH_W = 6;
	localparam int EEPROM_ADDR_W = 7;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int IRQ_SOURCES = 8;

	// Target of a write or table read.
	typedef enum logic [1:0] {
		TARGET_CODE,
		TARGET_INFO,
		TARGET_EEPROM
	} target_type;

	// One set-up write from the core.
	typedef struct packed {
		logic strobe;
		logic [2:0] sel;
		logic [7:0] data;
	} field_write_type;

	// One byte-program request to the memory arrays.
	typedef struct packed {
		target_type target;
		logic [13:0] addr;
		logic [7:0] data;
	} program_req_type;

endpackage

// *** logic/eeprom_code_write_sequencer.sv ***
// Byte-write sequencer and table-read router for code flash and EEPROM.
// Assumes the core, the memory arrays and the interrupt sources all run on
// clk; nothing here crosses a clock domain.
`timescale 1ns/1ps

module eeprom_code_write_sequencer
	import eeprom_seq_pkg::*;
#(
	parameter int HOLD_LONG_N = HOLD_LONG_CYCLES,
	parameter int HOLD_MID_N = HOLD_MID_CYCLES,
	parameter int HOLD_SHORT_N = HOLD_SHORT_CYCLES
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Set-up writes from the core and the code-protect option
	input wire field_write_type field_wr,
	input wire logic code_write_forbid,
	// Table reads from the core
	input wire logic table_rd,
	input wire logic [15:0] table_rd_addr,
	// Routed table read to the arrays
	output logic route_rd_r,
	output target_type route_target_r,
	output logic [13:0] route_addr_r,
	// Byte program to the arrays
	output logic program_strobe_r,
	output program_req_type program_req_r,
	// Core stall and status
	output logic stall_core_r,
	output logic armed,
	output logic [7:0] memory_region_select_r,
	output logic [7:0] program_data_byte_r,
	output logic [13:0] program_target_address_r,
	output logic [3:0] program_control_r,
	// Interrupt events held across the stall
	input wire logic [IRQ_SOURCES-1:0] irq_event,
	input wire logic [IRQ_SOURCES-1:0] irq_ack,
	output logic [IRQ_SOURCES-1:0] irq_request
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum logic {ST_IDLE, ST_HOLD} state_type;
	state_type state_r;
	logic [7:0] write_arming_count_r;
	logic [HOLD_CNT_W-1:0] hold_cnt_r;
	logic [HOLD_CNT_W-1:0] hold_len;
	logic [IRQ_SOURCES-1:0] irq_pending_r;
	logic [1:0] new_hold;
	logic [1:0] new_cmd;
	logic ctrl_wr;
	logic target_ok;
	logic start;
	target_type write_target;

	// ------------------------------------------------------------
	// Set-up fields
	// ------------------------------------------------------------
	assign ctrl_wr = field_wr.strobe && field_wr.sel == SEL_CONTROL;
	assign new_hold = field_wr.data[CTRL_HOLD_LSB +: 2];
	assign new_cmd = field_wr.data[CTRL_CMD_LSB +: 2];

	// The core cannot write while stalled, so the fields load freely.
	always_ff @(posedge clk) begin
		if (reset) begin
			memory_region_select_r <= BYTE_RESET;
			program_data_byte_r <= BYTE_RESET;
			program_target_address_r <= '0;
			program_control_r <= '0;
		end else if (clk_en && field_wr.strobe) begin
			unique case (field_wr.sel)
				SEL_REGION: memory_region_select_r <= field_wr.data;
				SEL_DATA: program_data_byte_r <= field_wr.data;
				SEL_ADDR_HIGH: program_target_address_r[13:8] <=
					field_wr.data[ADDR_HIGH_W-1:0];
				SEL_ADDR_LOW: program_target_address_r[7:0] <= field_wr.data;
				SEL_CONTROL: program_control_r <= field_wr.data[3:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Arming window
	// ------------------------------------------------------------
	// A nonzero count opens a window of that many clocks; a control write
	// closes it whether or not it starts anything, so each write re-arms.
	always_ff @(posedge clk) begin
		if (reset) begin
			write_arming_count_r <= BYTE_RESET;
		end else if (clk_en) begin
			if (field_wr.strobe && field_wr.sel == SEL_ARM) begin
				write_arming_count_r <= field_wr.data; // [RULE_05]
			end else if (ctrl_wr) begin
				write_arming_count_r <= BYTE_RESET; // [RULE_20]
			end else if (write_arming_count_r != BYTE_RESET) begin
				write_arming_count_r <= write_arming_count_r - 8'h01; // [RULE_05]
			end
		end
	end

	assign armed = write_arming_count_r != BYTE_RESET;

	// ------------------------------------------------------------
	// Start decision
	// ------------------------------------------------------------
	// Region one is read-only, reserved regions write nothing, and the
	// protect option locks the code area.
	always_comb begin
		write_target = TARGET_CODE;
		target_ok = 1'b0;
		unique case (memory_region_select_r)
			REGION_CODE: target_ok = !code_write_forbid; // [RULE_01] [RULE_11]
			REGION_EEPROM: begin
				write_target = TARGET_EEPROM; // [RULE_02]
				target_ok = 1'b1;
			end
			REGION_INFO: target_ok = 1'b0; // [RULE_19]
			default: target_ok = 1'b0;
		endcase
	end

	// Only command 10 with a defined hold code inside the window starts.
	assign start = clk_en && ctrl_wr && state_r == ST_IDLE && armed &&
		new_cmd == CMD_WRITE && new_hold != 2'h3 && target_ok; // [RULE_07] [RULE_17] [RULE_20]

	// Hold length in clocks for the requested hold code.
	always_comb begin
		hold_len = HOLD_CNT_W'(HOLD_LONG_N); // [RULE_16]
		unique case (new_hold)
			HOLD_MID: hold_len = HOLD_CNT_W'(HOLD_MID_N); // [RULE_16]
			HOLD_SHORT: hold_len = HOLD_CNT_W'(HOLD_SHORT_N); // [RULE_08]
			default: hold_len = HOLD_CNT_W'(HOLD_LONG_N);
		endcase
	end

	// ------------------------------------------------------------
	// Stall sequencer
	// ------------------------------------------------------------
	// The stall lasts exactly the hold length and then the core resumes.
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			stall_core_r <= 1'b0;
			hold_cnt_r <= '0;
		end else if (clk_en) begin
			unique case (state_r)
				ST_IDLE: if (start) begin
					state_r <= ST_HOLD;
					stall_core_r <= 1'b1; // [RULE_07]
					hold_cnt_r <= hold_len - HOLD_CNT_W'(1);
				end
				ST_HOLD: if (hold_cnt_r == '0) begin
					state_r <= ST_IDLE;
					stall_core_r <= 1'b0; // [RULE_09]
				end else begin
					hold_cnt_r <= hold_cnt_r - HOLD_CNT_W'(1);
				end
			endcase
		end
	end

	// One program pulse carries the byte, address and target to the array.
	always_ff @(posedge clk) begin
		if (reset) begin
			program_strobe_r <= 1'b0;
			program_req_r <= '0;
		end else if (clk_en) begin
			program_strobe_r <= start;
			if (start) begin
				program_req_r.target <= write_target; // [RULE_01] [RULE_02]
				program_req_r.addr <= program_target_address_r;
				program_req_r.data <= program_data_byte_r;
			end
		end
	end

	// ------------------------------------------------------------
	// Table-read routing
	// ------------------------------------------------------------
	// EEPROM reads take the offset from code address zero; reserved
	// region codes fall back to code flash.
	always_ff @(posedge clk) begin
		if (reset) begin
			route_rd_r <= 1'b0;
			route_target_r <= TARGET_CODE;
			route_addr_r <= '0;
		end else if (clk_en) begin
			route_rd_r <= table_rd;
			if (table_rd) begin
				route_addr_r <= table_rd_addr[13:0];
				unique case (memory_region_select_r)
					REGION_INFO: route_target_r <= TARGET_INFO; // [RULE_12] [RULE_19]
					REGION_EEPROM: begin
						route_target_r <= TARGET_EEPROM; // [RULE_12] [RULE_14]
						route_addr_r <= {7'h00,
							table_rd_addr[EEPROM_ADDR_W-1:0]}; // [RULE_14]
					end
					default: route_target_r <= TARGET_CODE; // [RULE_01] [RULE_14]
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupts across the stall
	// ------------------------------------------------------------
	// Events stay pending while stalled; repeats collapse into one bit
	// and a new event beats an acknowledge in the same cycle.
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_pending_r <= '0;
		end else if (clk_en) begin
			irq_pending_r <= irq_event | (irq_pending_r & ~irq_ack); // [RULE_18]
		end
	end

	assign irq_request = stall_core_r ? '0 : irq_pending_r; // [RULE_18]

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking chk_cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence arm_write_s;
		clk_en && field_wr.strobe && field_wr.sel == SEL_ARM &&
			field_wr.data != 8'h00;
	endsequence

	sequence started_s;
		$rose(stall_core_r);
	endsequence

	arm_opens_a: assert property (arm_write_s |=> armed) // [RULE_05]
		else $error("arming write did not open the window");

	arm_closes_a: assert property ( // [RULE_05]
		clk_en && !field_wr.strobe && write_arming_count_r == 8'h01 |=> !armed)
		else $error("arming window did not close on time");

	unarmed_ignored_a: assert property ( // [RULE_20]
		ctrl_wr && clk_en && !armed |=> !$rose(stall_core_r))
		else $error("unarmed command stalled the core");

	bad_cmd_a: assert property ( // [RULE_17]
		ctrl_wr && clk_en && new_cmd != CMD_WRITE |=> !$rose(stall_core_r))
		else $error("reserved command started a write");

	protect_a: assert property ( // [RULE_11]
		program_strobe_r |-> !($past(code_write_forbid) &&
			program_req_r.target == TARGET_CODE))
		else $error("protected code area was written");

	info_ro_a: assert property ( // [RULE_19]
		program_strobe_r |-> $past(memory_region_select_r) != REGION_INFO)
		else $error("information block was written");

	stall_pulse_a: assert property ( // [RULE_07]
		started_s |-> program_strobe_r)
		else $error("stall started without a program pulse");

	short_hold_a: assert property ( // [RULE_08]
		start && new_hold == HOLD_SHORT && HOLD_SHORT_N <= 8
			|=> stall_core_r [*1] ##0 (hold_cnt_r ==
			HOLD_CNT_W'(HOLD_SHORT_N - 1)))
		else $error("short hold loaded a wrong length");

	release_a: assert property ( // [RULE_09]
		clk_en && state_r == ST_HOLD && hold_cnt_r == '0 |=> !stall_core_r)
		else $error("stall not released at the end of the hold");

	eeprom_route_a: assert property ( // [RULE_14]
		clk_en && table_rd && memory_region_select_r == REGION_EEPROM |=>
			route_target_r == TARGET_EEPROM &&
			route_addr_r == {7'h00, $past(table_rd_addr[6:0])})
		else $error("EEPROM table read misrouted");

	irq_hold_a: assert property ( // [RULE_18]
		stall_core_r |-> irq_request == '0)
		else $error("interrupt delivered during stall");

endmodule

// *** tb/core_model.sv ***
// Core-side model: set-up writes and table reads towards the sequencer.
// Assumes clk is the sequencer clock; stall is its core stall output.
`timescale 1ns/1ps

module core_model
	import eeprom_seq_pkg::*;
(
	// Clock and stall
	input wire logic clk,
	input wire logic stall,
	// Requests to the sequencer
	output field_write_type fw,
	output logic rd,
	output logic [15:0] rd_addr
);
	// Idle values at time zero.
	initial begin
		fw = '{1'b0, 3'h7, 8'h00};
		rd = 1'b0;
		rd_addr = 16'h0000;
	end

	// One set-up write; released data shows the inverse byte.
	task automatic put(input logic [2:0] s, input logic [7:0] d);
		@(posedge clk);
		fw <= '{1'b1, s, d};
		@(posedge clk);
		fw <= '{1'b0, 3'h7, ~d};
	endtask

	// Region, data, address and arming, in the documented order.
	task automatic setup(input logic [7:0] r, d, input logic [13:0] a);
		put(SEL_REGION, r);
		put(SEL_DATA, d);
		put(SEL_ADDR_HIGH, {2'h0, a[13:8]});
		put(SEL_ADDR_LOW, a[7:0]);
		put(SEL_ARM, 8'hf0);
	endtask

	// Eight executed slots after a write command; stalled edges do not
	// count, and the loop gives up after a bounded number of edges.
	task automatic nops();
		int k;
		k = 0;
		for (int i = 0; i < 1000 && k < 8; i++) begin
			@(posedge clk);
			if (stall !== 1'b1)
				k++;
		end
	endtask

	// One table read pulse; the address is scrambled once released.
	task automatic read(input logic [15:0] a);
		@(posedge clk);
		rd <= 1'b1;
		rd_addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		rd_addr <= ~a;
	endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the byte-write sequencer.
// Assumes short hold counts of 8, 6 and 4 cycles and a 50 ns clock.
`timescale 1ns/1ps

module testbench;
	import eeprom_seq_pkg::*;
	localparam int NL = 8;
	localparam int NM = 6;
	localparam int NS = 4;
	logic clk, reset, forbid, rd, stb, stall, armed_w, route_rd, ce;
	logic [7:0] data_q;
	logic [13:0] addr_q;
	logic [3:0] ctrl_q;
	logic [7:0] irq_ev, irq_ack, region, irq_req;
	logic [15:0] rd_addr;
	logic [13:0] route_addr;
	target_type route_tgt;
	field_write_type fw;
	program_req_type req;
	int num_errors = 0;
	int total_checks = 0;
	int len;

	// Device under test with shortened hold counts.
	eeprom_code_write_sequencer #(.HOLD_LONG_N(NL), .HOLD_MID_N(NM),
		.HOLD_SHORT_N(NS)) DUT (.clk(clk), .reset(reset), .clk_en(ce),
		.field_wr(fw), .code_write_forbid(forbid), .table_rd(rd),
		.table_rd_addr(rd_addr), .route_rd_r(route_rd),
		.route_target_r(route_tgt), .route_addr_r(route_addr),
		.program_strobe_r(stb), .program_req_r(req), .stall_core_r(stall),
		.armed(armed_w), .memory_region_select_r(region),
		.program_data_byte_r(data_q),
		.program_target_address_r(addr_q),
		.program_control_r(ctrl_q), .irq_event(irq_ev), .irq_ack(irq_ack),
		.irq_request(irq_req));

	// Core model on the far side.
	core_model core (.clk(clk), .stall(stall), .fw(fw), .rd(rd),
		.rd_addr(rd_addr));

	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Compare tasks, one per kind of result, and the verdict.
	task automatic chk1(input logic g, e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chkv(input logic [23:0] g, e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Counts stall cycles from the sample after the command edge.
	task automatic stall_len();
		len = 0;
		while (stall === 1'b1) begin
			@(posedge clk);
			#1;
			len++;
			if (len > 1000) begin
				num_errors++;
				close_out();
			end
		end
	endtask

	// Full write; n is the expected stall length, zero when refused.
	task automatic prog(input logic [7:0] r, c, d, input logic [13:0] a,
		input int n);
		logic [1:0] t;
		t = (r == REGION_EEPROM) ? TARGET_EEPROM : TARGET_CODE;
		core.setup(r, d, a);
		core.put(SEL_CONTROL, c);
		#1;
		chkv({data_q, addr_q}, {d, a});
		chkv(ctrl_q, c[3:0]);
		chk1(stb, n > 0);
		if (n > 0)
			chkv(req, {t, a, d});
		stall_len();
		chkv(len[23:0], n[23:0]);
		core.nops();
		core.put(SEL_REGION, REGION_CODE);
	endtask

	// Table read under region r, then the read pulse must drop again.
	task automatic rd_chk(input logic [7:0] r, input logic [15:0] a,
		input logic [1:0] t);
		core.put(SEL_REGION, r);
		core.read(a);
		#1;
		chkv({route_rd, route_tgt}, {1'b1, t});
		if (t == TARGET_EEPROM)
			chkv(route_addr, {7'h00, a[EEPROM_ADDR_W-1:0]});
		else
			chkv(route_addr, a[13:0]);
		@(posedge clk);
		#1;
		chk1(route_rd, 1'b0);
	endtask

	// Main sequence.
	initial begin
		reset = 1'b1;
		forbid = 1'b0;
		ce = 1'b1;
		irq_ev = 8'h00;
		irq_ack = 8'h00;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1;
		chkv({stall, armed_w, region, irq_req}, 24'h0);
		prog(REGION_EEPROM, 8'h0a, 8'h5a, 14'h0012, NS);
		prog(REGION_CODE, 8'h02, 8'hc3, 14'h2a5c, NL);
		prog(REGION_CODE, 8'h06, 8'h3c, 14'h3fff, NM);
		prog(REGION_CODE, 8'h0e, 8'h11, 14'h0100, 0);
		for (int c = 0; c < 4; c++)
			if (c != 2)
				prog(REGION_EEPROM, 8'h08 | 8'(c), 8'h22, 14'h0001, 0);
		prog(REGION_INFO, 8'h0a, 8'h33, 14'h0002, 0);
		@(posedge clk);
		forbid <= 1'b1;
		prog(REGION_CODE, 8'h0a, 8'h44, 14'h0203, 0);
		prog(REGION_EEPROM, 8'h0a, 8'h77, 14'h007f, NS);
		@(posedge clk);
		forbid <= 1'b0;
		// Arming window of three cycles, frozen for four by the enable,
		// then a late command.
		core.put(SEL_ARM, 8'h03);
		ce <= 1'b0;
		#1;
		chk1(armed_w, 1'b1);
		repeat (4) @(posedge clk);
		ce <= 1'b1;
		#1;
		chk1(armed_w, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk1(armed_w, 1'b1);
		@(posedge clk);
		#1;
		chk1(armed_w, 1'b0);
		core.put(SEL_CONTROL, 8'h0a);
		#1;
		chkv({stall, stb}, 24'h0);
		rd_chk(REGION_EEPROM, 16'h0025, TARGET_EEPROM);
		rd_chk(REGION_INFO, 16'h0003, TARGET_INFO);
		rd_chk(REGION_CODE, 16'h1234, TARGET_CODE);
		// Interrupt events during a stall are held and merged.
		core.setup(REGION_EEPROM, 8'h66, 14'h0040);
		core.put(SEL_CONTROL, 8'h0a);
		irq_ev <= 8'h08;
		@(posedge clk);
		irq_ev <= 8'h00;
		@(posedge clk);
		irq_ev <= 8'h08;
		@(posedge clk);
		irq_ev <= 8'h00;
		#1;
		chkv(irq_req, 8'h00);
		stall_len();
		chkv(irq_req, 8'h08);
		@(posedge clk);
		irq_ack <= 8'h08;
		@(posedge clk);
		irq_ack <= 8'h00;
		#1;
		chkv(irq_req, 8'h00);
		close_out();
	end
endmodule
